// ### verilog/lpg_pkg.sv
// constants and types shared by the lamp pwm generator
package lpg_pkg;
   // register map (word offsets of the device register file)
   localparam logic [7:0]  LPG_ADDR_AB      = 8'h08;
   localparam logic [7:0]  LPG_ADDR_CD      = 8'h09;
   localparam logic [15:0] LPG_REG_RESET    = 16'h0000;
   // field positions inside one byte of a setting register
   localparam int          LPG_FREQ_BIT     = 7;
   localparam int          LPG_DUTY_W       = 7;
   localparam int          LPG_EXT_W        = 10;
   localparam int          LPG_HI_BYTE      = 8;
   // duty is (code + 1) / 2**width
   localparam int          LPG_SHIFT_STD    = 7;
   localparam int          LPG_SHIFT_EXT    = 10;
   // timing
   localparam int          LPG_CLK_HZ       = 20_000_000;
   localparam int          LPG_FREQ_LO_HZ   = 170;
   localparam int          LPG_FREQ_HI_HZ   = 225;
   localparam int          LPG_CNT_W        = 17;
   localparam int          LPG_PERIOD_LO    = LPG_CLK_HZ / LPG_FREQ_LO_HZ;
   localparam int          LPG_PERIOD_HI    = LPG_CLK_HZ / LPG_FREQ_HI_HZ;
   localparam int          LPG_NUM_LAMPS    = 4;

   typedef logic [LPG_CNT_W-1:0] lpg_cnt_t;

   // one byte of a setting register
   typedef struct packed {
      logic                  freq_sel;
      logic [LPG_DUTY_W-1:0] duty;
   } lpg_lamp_s;

   // register write strobe with its data
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [15:0] data;
   } lpg_wr_s;
endpackage : lpg_pkg

// ### verilog/lpg_lamp_pwm.sv
// four-channel internal pwm generator for the high-side lamp outputs
`timescale 1ns/1ps

// Notes on behaviour
// - each lamp duty is (7-bit field + 1) / 128; fields reset to zero
// - per-lamp frequency bit: 0 gives 170 Hz, 1 gives 225 Hz
// - outputs follow the generator only while internal pwm enable is set
// - resolution-extend bit switches each lamp to a 10-bit duty code
// - second register: lamp c setting in high byte, lamp d in low byte
module lpg_lamp_pwm #(
   parameter lpg_pkg::lpg_cnt_t PERIOD_LO = lpg_pkg::lpg_cnt_t'(lpg_pkg::LPG_PERIOD_LO),
   parameter lpg_pkg::lpg_cnt_t PERIOD_HI = lpg_pkg::lpg_cnt_t'(lpg_pkg::LPG_PERIOD_HI)
) (
   // clock and reset
   input  wire logic                                mclk_i,
   input  wire logic                                rst_i,
   // register file port
   input  wire lpg_pkg::lpg_wr_s                    reg_wr_i,
   input  wire logic [7:0]                          rd_addr_i,
   output logic      [15:0]                         rd_data_o,
   // configuration from the control and config registers
   input  wire logic                                internal_pwm_enable_i,
   input  wire logic                                duty_resolution_extend_i,
   input  wire logic [lpg_pkg::LPG_NUM_LAMPS-1:0][lpg_pkg::LPG_EXT_W-1:0] ext_duty_i,
   // gating for the lamp power stages: a, b, c, d in bits 0..3
   output logic      [lpg_pkg::LPG_NUM_LAMPS-1:0]   lamp_output_o
);
   import lpg_pkg::*;

   // on-time in cycles for a period length and a duty code; the product is
   // wide enough for the largest period times the largest code, and the
   // shift truncates, so a very short period can round a small duty to zero
   function automatic lpg_cnt_t on_time(input lpg_cnt_t per, input logic [LPG_EXT_W-1:0] code,
                                        input logic ext);
      logic [LPG_CNT_W+LPG_EXT_W:0] prod;
      prod = '0;
      if (ext) begin
         prod = per * ({1'b0, code} + 11'h001);
         on_time = lpg_cnt_t'(prod >> LPG_SHIFT_EXT);
      end else begin
         prod = per * ({4'h0, code[LPG_DUTY_W-1:0]} + 11'h001);
         on_time = lpg_cnt_t'(prod >> LPG_SHIFT_STD);
      end
   endfunction : on_time

   // settings per lamp, then the per-lamp period state that loads at wraps
   lpg_lamp_s [LPG_NUM_LAMPS-1:0] set_r, set_nxt;
   lpg_cnt_t  [LPG_NUM_LAMPS-1:0] cnt_r, cnt_nxt;
   lpg_cnt_t  [LPG_NUM_LAMPS-1:0] period_r, period_nxt;
   lpg_cnt_t  [LPG_NUM_LAMPS-1:0] thr_r, thr_nxt;
   logic      [LPG_NUM_LAMPS-1:0] out_nxt;
   logic      [15:0]              rd_nxt;

   // register writes: lamp a/c in the high byte, b/d in the low byte
   // a write to any other offset is dropped; there is no answer to wait for
   always_comb begin
      set_nxt = set_r;
      if (reg_wr_i.wr) begin
         if (reg_wr_i.addr == LPG_ADDR_AB) begin
            set_nxt[0] = reg_wr_i.data[15:LPG_HI_BYTE];
            set_nxt[1] = reg_wr_i.data[LPG_HI_BYTE-1:0];
         end else if (reg_wr_i.addr == LPG_ADDR_CD) begin
            set_nxt[2] = reg_wr_i.data[15:LPG_HI_BYTE];
            set_nxt[3] = reg_wr_i.data[LPG_HI_BYTE-1:0];
         end
      end
   end

   // readback; unmapped offsets read zero
   // the address is a level, so a read has no side effect on the settings
   always_comb begin
      rd_nxt = '0;
      if (rd_addr_i == LPG_ADDR_AB) begin
         rd_nxt = {set_r[0], set_r[1]};
      end else if (rd_addr_i == LPG_ADDR_CD) begin
         rd_nxt = {set_r[2], set_r[3]};
      end
   end

   // period counters; settings are sampled only at the wrap so a write
   // in mid-period never produces a runt or stretched pulse
   // limitation: the resolution-extend bit is shared by all lamps and is
   // picked up by each lamp at its own next wrap, not at one common instant
   always_comb begin
      cnt_nxt    = cnt_r;
      period_nxt = period_r;
      thr_nxt    = thr_r;
      out_nxt    = '0;
      for (int i = 0; i < LPG_NUM_LAMPS; i++) begin
         if (cnt_r[i] >= period_r[i] - 17'h00001) begin
            cnt_nxt[i]    = '0;
            period_nxt[i] = set_r[i].freq_sel ? PERIOD_HI : PERIOD_LO;
            thr_nxt[i]    = on_time(period_nxt[i],
                                    duty_resolution_extend_i ? ext_duty_i[i]
                                       : {3'h0, set_r[i].duty},
                                    duty_resolution_extend_i);
         end else begin
            cnt_nxt[i] = cnt_r[i] + 17'h00001;
         end
         // high from the start of the period until the threshold
         out_nxt[i] = internal_pwm_enable_i && (cnt_nxt[i] < thr_nxt[i]);
      end
   end

   // settings register; a write lands on the edge that takes the strobe
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         set_r <= {(LPG_NUM_LAMPS/2){LPG_REG_RESET}};
      end else begin
         set_r <= set_nxt;
      end
   end

   // readback register, one cycle behind the address
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= rd_nxt;
      end
   end

   // counters and gating; counters start at a boundary after reset with a
   // zero threshold, so the first period after reset is all-off
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         lamp_output_o <= '0;
         for (int i = 0; i < LPG_NUM_LAMPS; i++) begin
            cnt_r[i]    <= '0;
            period_r[i] <= PERIOD_LO;
            thr_r[i]    <= '0;
         end
      end else begin
         lamp_output_o <= out_nxt;
         cnt_r         <= cnt_nxt;
         period_r      <= period_nxt;
         thr_r         <= thr_nxt;
      end
   end

   // checks, written against lamp a unless the rule names another lamp or, as the disable rule does, all four lamps;
   // the first period after reset is all-off by design, so checks on a
   // freshly loaded threshold wait for a real wrap, told apart from the
   // reset state by a nonzero count in the cycle before
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   chk_disable_gates_off: assert property (
      !internal_pwm_enable_i |=> lamp_output_o == '0)
      else $error("lamp output active while internal pwm disabled");

   chk_period_start_on: assert property (
      cnt_r[0] == '0 |->
         lamp_output_o[0] == ($past(internal_pwm_enable_i) && thr_r[0] != '0))
      else $error("lamp a not on at period start");

   chk_freq_select: assert property (
      cnt_r[0] == '0 |->
         period_r[0] == ($past(set_r[0].freq_sel) ? PERIOD_HI : PERIOD_LO))
      else $error("lamp a period does not match its frequency bit");

   chk_lamp_b_freq: assert property (
      cnt_r[1] == '0 |->
         period_r[1] == ($past(set_r[1].freq_sel) ? PERIOD_HI : PERIOD_LO))
      else $error("lamp b period does not match its frequency bit");

   chk_duty_std: assert property (
      cnt_r[0] == '0 && $past(cnt_r[0]) != '0 && !$past(duty_resolution_extend_i) |->
         thr_r[0] == on_time(period_r[0], {3'h0, $past(set_r[0].duty)}, 1'b0))
      else $error("lamp a on-time does not follow the 7-bit field");

   chk_duty_ext: assert property (
      cnt_r[0] == '0 && $past(cnt_r[0]) != '0 && $past(duty_resolution_extend_i) |->
         thr_r[0] == on_time(period_r[0], $past(ext_duty_i[0]), 1'b1))
      else $error("lamp a on-time does not follow the 10-bit code");

   chk_thr_within_period: assert property (
      thr_r[0] <= period_r[0])
      else $error("lamp a on-time longer than its period");

   chk_ab_write_bytes: assert property (
      reg_wr_i.wr && reg_wr_i.addr == LPG_ADDR_AB |=>
         set_r[0] == $past(reg_wr_i.data[15:LPG_HI_BYTE]) &&
         set_r[1] == $past(reg_wr_i.data[LPG_HI_BYTE-1:0]))
      else $error("first setting register bytes misplaced");

   chk_lamp_d_low_byte: assert property (
      reg_wr_i.wr && reg_wr_i.addr == LPG_ADDR_CD |=>
         set_r[3] == $past(reg_wr_i.data[LPG_HI_BYTE-1:0]) &&
         set_r[2] == $past(reg_wr_i.data[15:LPG_HI_BYTE]))
      else $error("second setting register bytes misplaced");

   chk_readback_ab: assert property (
      rd_addr_i == LPG_ADDR_AB |=> rd_data_o == {$past(set_r[0]), $past(set_r[1])})
      else $error("first setting register reads back wrong");

   chk_readback_cd: assert property (
      rd_addr_i == LPG_ADDR_CD |=> rd_data_o == {$past(set_r[2]), $past(set_r[3])})
      else $error("second setting register reads back wrong");

   chk_mid_period_hold: assert property (
      cnt_r[0] != '0 |-> $stable(period_r[0]) && $stable(thr_r[0]))
      else $error("lamp a settings changed inside a period");

   chk_output_follows_count: assert property (
      lamp_output_o[0] == ($past(internal_pwm_enable_i) && cnt_r[0] < thr_r[0]))
      else $error("lamp a output does not follow its counter");

   chk_lamp_d_gating: assert property (
      lamp_output_o[3] == ($past(internal_pwm_enable_i) && cnt_r[3] < thr_r[3]))
      else $error("lamp d gating does not follow enable and counter");

   chk_count_advance: assert property (
      cnt_r[0] != '0 |-> cnt_r[0] == $past(cnt_r[0]) + 17'h00001)
      else $error("lamp a counter skipped a step");

   chk_count_in_period: assert property (
      cnt_r[0] < period_r[0])
      else $error("lamp a counter ran past its period");

   // covers for the main scenarios: full duty, fast period, extended
   // resolution, a disabled stretch and a write to the second register
   cov_full_duty:   cover property (set_r[0].duty == 7'h7f && cnt_r[0] == '0);
   cov_fast_period: cover property (set_r[1].freq_sel && cnt_r[1] == '0 ##1 cnt_r[1] != '0);
   cov_ext_pulse:   cover property (duty_resolution_extend_i && $fell(lamp_output_o[2]));
   cov_gated_off:   cover property (!internal_pwm_enable_i ##1 lamp_output_o == '0);
   cov_cd_write:    cover property (reg_wr_i.wr && reg_wr_i.addr == LPG_ADDR_CD);
endmodule : lpg_lamp_pwm

// ### verif/lpg_stage_model.sv
// behavioural lamp power stages: count on-cycles of each gated output
`timescale 1ns/1ps
module lpg_stage_model (
   // clock and window clear
   input  wire logic             mclk_i,
   input  wire logic             clr_i,
   // gating from the generator, a..d in bits 0..3
   input  wire logic [3:0]       gate_i,
   output logic      [3:0][15:0] on_cnt_o
);
   // a stage is on for each clock edge its gate is high; clear opens a new window
   always_ff @(posedge mclk_i) begin
      for (int i = 0; i < 4; i++) begin
         on_cnt_o[i] <= clr_i ? 16'h0000 : on_cnt_o[i] + 16'(gate_i[i]);
      end
   end
endmodule : lpg_stage_model

// ### verif/testbench.sv
// self-checking bench for the lamp pwm generator
`timescale 1ns/1ps
module testbench;
   import lpg_pkg::*;
   logic             mclk_i = 1'b0;
   logic             rst_i  = 1'b1;
   lpg_wr_s          wr_s   = '0;
   logic [7:0]       rd_a   = 8'h00;
   logic [15:0]      rd_d;
   logic             en     = 1'b1;
   logic             ext    = 1'b0;
   logic             clr    = 1'b0;
   logic [3:0][9:0]  xd     = '0;
   logic [3:0]       lamp;
   logic [3:0][15:0] cnt;
   int               n_mismatch = 0;
   int               num_checks = 0;
   always #25 mclk_i = ~mclk_i;
   // short periods: 384 cycles hold whole periods of both rates
   lpg_lamp_pwm #(.PERIOD_LO(17'd128), .PERIOD_HI(17'd96)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
      .reg_wr_i(wr_s), .rd_addr_i(rd_a), .rd_data_o(rd_d), .internal_pwm_enable_i(en),
      .duty_resolution_extend_i(ext), .ext_duty_i(xd), .lamp_output_o(lamp));
   lpg_stage_model stage (.mclk_i(mclk_i), .clr_i(clr), .gate_i(lamp), .on_cnt_o(cnt));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge mclk_i) wr_s = '{1'b1, a, d};
      @(negedge mclk_i) wr_s.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge mclk_i) rd_a = a;
      @(negedge mclk_i) d = rd_d;
   endtask : rd
   // on-cycles expected in a 384-cycle window
   function automatic logic [15:0] exp_on(input logic f, input logic [9:0] c, input logic x);
      int per;
      per = f ? 96 : 128;
      return 16'((384 / per) * ((per * (int'(c) + 1)) >> (x ? 10 : 7)));
   endfunction : exp_on
   // program both registers, let old periods drain, then measure one window
   task automatic run(input logic [15:0] ab, input logic [15:0] cd);
      logic [31:0] v;
      logic [7:0]  b;
      logic [15:0] r;
      v = {ab, cd};
      wr(LPG_ADDR_AB, ab);
      wr(LPG_ADDR_CD, cd);
      rd(LPG_ADDR_AB, r);
      chk(r, ab);
      rd(LPG_ADDR_CD, r);
      chk(r, cd);
      repeat (384) @(negedge mclk_i);
      clr = 1'b1;
      @(negedge mclk_i) clr = 1'b0;
      repeat (384) @(negedge mclk_i);
      for (int i = 0; i < 4; i++) begin
         b = v[31-8*i -: 8];
         chk(cnt[i], en ? exp_on(b[7], ext ? xd[i] : {3'b000, b[6:0]}, ext) : 16'h0000);
      end
      $display("test done ab=%h cd=%h en=%b ext=%b", ab, cd, en, ext);
   endtask : run
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   // main sequence
   initial begin
      logic [15:0] r;
      repeat (16) @(negedge mclk_i);
      rst_i = 1'b0;
      rd(LPG_ADDR_AB, r);
      chk(r, LPG_REG_RESET);
      wr(8'h0a, 16'hffff);
      rd(8'h0a, r);
      chk(r, 16'h0000);
      $display("test done reset values and unmapped offset");
      run(16'h0000, 16'h0000);
      run(16'hff80, 16'h7f8a);
      run(16'h8a2b, 16'h3cbf);
      en = 1'b0;
      run(16'hffff, 16'hffff);
      en = 1'b1;
      ext = 1'b1;
      xd = {10'h000, 10'h07f, 10'h1ff, 10'h3ff};
      run(16'h8000, 16'h0080);
      results();
   end
   // a hang ends the run well past the few thousand cycles needed
   initial begin
      #(50 * 20000);
      n_mismatch++;
      results();
   end
endmodule : testbench
